// ### hw/tpc_prescale.sv
// 1/8/64/256 input prescaler for one timer
`timescale 1ns/10ps
`default_nettype none
`include "tpc_defs.svh"
module tpc_prescale (
    input  wire logic       clk,      // device clock
    input  wire logic       rst_b,    // async reset, active low
    input  wire logic       clear,    // hold counter at zero
    input  wire logic       tick_in,  // input clock event
    input  wire logic [1:0] sel,      // prescale select
    output logic            tick_out  // divided event
);
    typedef struct packed {
        logic [7:0] cnt;
    } tpc_ps_s;

    tpc_ps_s    st;
    tpc_ps_s    next_st;
    logic [7:0] last;

    function automatic logic [7:0] last_count(input logic [1:0] s);
        unique case (s)
            2'b00: last_count = `TPC_PS_LAST_1;
            2'b01: last_count = `TPC_PS_LAST_8;
            2'b10: last_count = `TPC_PS_LAST_64;
            2'b11: last_count = `TPC_PS_LAST_256;
        endcase
    endfunction : last_count

    assign last = last_count(sel);
    // >= so a ratio lowered mid-count cannot overrun to 255
    assign tick_out = tick_in && (st.cnt >= last);

    always_comb begin
        next_st = st;
        if (clear) begin
            next_st.cnt = 8'h00;
        end else if (tick_in) begin
            next_st.cnt = (st.cnt >= last) ? 8'h00 : st.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : tpc_prescale
`default_nettype wire

// ### hw/tpc_sync3.sv
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module tpc_sync3 #(
    parameter int W = 4
) (
    input  wire logic         clk,   // device clock
    input  wire logic         rst_b, // async reset, active low
    input  wire logic [W-1:0] din,   // raw pin levels
    output logic      [W-1:0] dout   // filtered levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } tpc_sync_s;

    tpc_sync_s st;
    tpc_sync_s next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.q;
endmodule : tpc_sync3
`default_nettype wire

// ### hw/tpc_top.sv
// timer pair: lower and upper 16-bit timers, chainable into one 32-bit timer
`timescale 1ns/10ps
`default_nettype none
`include "tpc_defs.svh"
module tpc_top #(
    parameter bit HAS_DMA = 1'b1 // pair may request memory transfers
) (
    input  wire logic        clk,                         // device clock
    input  wire logic        rst_b,                       // async reset
    input  wire logic [4:0]  avs_address,                 // byte address
    input  wire logic        avs_read,                    // read request
    input  wire logic        avs_write,                   // write request
    input  wire logic [31:0] avs_writedata,               // write data
    input  wire logic [3:0]  avs_byteenable,              // byte lanes
    output logic      [31:0] avs_readdata,                // read data
    output logic             avs_waitrequest,             // stall
    input  wire logic        external_timer_clock_pin_lo, // lower ext clock
    input  wire logic        external_timer_clock_pin_hi, // upper ext clock
    input  wire logic        gate_pin_lo,                 // lower gate
    input  wire logic        gate_pin_hi,                 // upper gate
    input  wire logic        idle_mode,                   // device idle
    output logic             irq_lo,                      // lower irq
    output logic             irq_hi,                      // upper irq
    output logic      [2:0]  irq_priority_lo,             // lower priority
    output logic      [2:0]  irq_priority_hi,             // upper priority
    output logic             adc_trigger,                 // conversion start
    output logic             dma_req_lo,                  // lower dma pulse
    output logic             dma_req_hi                   // upper dma pulse
);
    tpc_pkg::tpc_top_s st;
    tpc_pkg::tpc_top_s next_st;

    logic [3:0]  pin_s;
    logic        cat;
    logic        run_lo;
    logic        run_hi;
    logic        ps_in_lo;
    logic        ps_in_hi;
    logic        ps_out_lo;
    logic        ps_out_hi;
    logic        tick_lo;
    logic        tick_hi;
    logic        gfall_lo;
    logic        gfall_hi;
    logic [31:0] cnt32;
    logic [31:0] per32;
    logic        wr_ack;
    logic [4:0]  word_addr;

    function automatic logic [16:0] step16(input logic [15:0] c, input logic [15:0] p);
        step16 = (c == p) ? 17'h1_0000 : {1'b0, c + 16'h0001};
    endfunction : step16

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  be);
        merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    tpc_sync3 #(.W(4)) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   ({gate_pin_hi, gate_pin_lo,
                 external_timer_clock_pin_hi, external_timer_clock_pin_lo}),
        .dout  (pin_s)
    );

    assign cat = st.ctl_lo[`TPC_BIT_CAT];
    // chained: lower run bit drives both halves, upper run bit ignored
    assign run_lo = st.ctl_lo[`TPC_BIT_ON] && !(idle_mode && (st.ctl_lo[`TPC_BIT_SIDL] ||
                    (cat && st.ctl_hi[`TPC_BIT_SIDL])));
    assign run_hi = st.ctl_hi[`TPC_BIT_ON] && !cat &&
                    !(idle_mode && st.ctl_hi[`TPC_BIT_SIDL]);

    // mode decode: external pin edge, gated internal or plain internal
    assign ps_in_lo = run_lo && (st.ctl_lo[`TPC_BIT_CS] ? (pin_s[0] && !st.ext_d_lo) :
                      (!st.ctl_lo[`TPC_BIT_GATE] || pin_s[2]));
    assign ps_in_hi = run_hi && (st.ctl_hi[`TPC_BIT_CS] ? (pin_s[1] && !st.ext_d_hi) :
                      (!st.ctl_hi[`TPC_BIT_GATE] || pin_s[3]));
    assign gfall_lo = run_lo && !st.ctl_lo[`TPC_BIT_CS] && st.ctl_lo[`TPC_BIT_GATE] &&
                      st.gate_d_lo && !pin_s[2];
    assign gfall_hi = run_hi && !st.ctl_hi[`TPC_BIT_CS] && st.ctl_hi[`TPC_BIT_GATE] &&
                      st.gate_d_hi && !pin_s[3];

    tpc_prescale u_ps_lo (
        .clk      (clk),
        .rst_b    (rst_b),
        .clear    (!run_lo),
        .tick_in  (ps_in_lo),
        .sel      (st.ctl_lo[`TPC_BIT_PS_HI:`TPC_BIT_PS_LO]),
        .tick_out (ps_out_lo)
    );

    tpc_prescale u_ps_hi (
        .clk      (clk),
        .rst_b    (rst_b),
        .clear    (!run_hi),
        .tick_in  (ps_in_hi),
        .sel      (st.ctl_hi[`TPC_BIT_PS_HI:`TPC_BIT_PS_LO]),
        .tick_out (ps_out_hi)
    );

    // external path of the lower half is retimed behind its prescaler
    assign tick_lo = st.ctl_lo[`TPC_BIT_CS] ? (st.tick_b && run_lo) : ps_out_lo;
    assign tick_hi = ps_out_hi;
    assign cnt32 = {st.cnt_hi, st.cnt_lo};
    assign per32 = {st.per_hi, st.per_lo};
    assign wr_ack = avs_write && (st.bus == tpc_pkg::TPC_BUS_ACK);
    assign word_addr = {avs_address[4:2], 2'b00};

    always_comb begin
        logic        set_lo;
        logic        set_hi;
        logic        wrap;
        logic [15:0] irqv;
        set_lo = 1'b0;
        set_hi = 1'b0;
        wrap = 1'b0;
        irqv = {1'b0, st.ip_hi, 1'b0, st.ip_lo, 2'b00, st.ie_hi, st.ie_lo,
                2'b00, st.flag_hi, st.flag_lo};
        next_st = st;
        next_st.adc = 1'b0;
        next_st.dma_lo = 1'b0;
        next_st.dma_hi = 1'b0;
        next_st.ext_d_lo = pin_s[0];
        next_st.ext_d_hi = pin_s[1];
        next_st.gate_d_lo = pin_s[2];
        next_st.gate_d_hi = pin_s[3];
        next_st.tick_b = ps_out_lo;

        if (!cat) begin
            if (tick_lo) begin
                {wrap, next_st.cnt_lo} = step16(st.cnt_lo, st.per_lo);
                set_lo = wrap;
                next_st.dma_lo = wrap && HAS_DMA;
            end
            set_lo = set_lo || gfall_lo;
        end else begin
            if (tick_lo) begin
                if (cnt32 == per32) begin
                    next_st.cnt_lo = 16'h0000;
                    next_st.cnt_hi = 16'h0000;
                    set_hi = 1'b1;
                    next_st.adc = 1'b1;
                    next_st.dma_hi = HAS_DMA;
                end else begin
                    {next_st.cnt_hi, next_st.cnt_lo} = cnt32 + 32'h0000_0001;
                end
            end
            set_hi = set_hi || gfall_lo;
        end
        if (tick_hi) begin
            {wrap, next_st.cnt_hi} = step16(st.cnt_hi, st.per_hi);
            set_hi = set_hi || wrap;
            next_st.dma_hi = wrap && HAS_DMA;
        end
        set_hi = set_hi || gfall_hi;

        if (st.bus == tpc_pkg::TPC_BUS_IDLE) begin
            if (avs_read || avs_write) begin
                next_st.bus = tpc_pkg::TPC_BUS_ACK;
                unique case (word_addr)
                    `TPC_OFF_CTL_LO: next_st.rdata = {16'h0000, st.ctl_lo};
                    `TPC_OFF_CTL_HI: next_st.rdata = {16'h0000, st.ctl_hi};
                    `TPC_OFF_CNT_LO: next_st.rdata = {16'h0000, st.cnt_lo};
                    `TPC_OFF_CNT_HI: next_st.rdata = {16'h0000, st.cnt_hi};
                    `TPC_OFF_PER_LO: next_st.rdata = {16'h0000, st.per_lo};
                    `TPC_OFF_PER_HI: next_st.rdata = {16'h0000, st.per_hi};
                    `TPC_OFF_IRQ:    next_st.rdata = {16'h0000, irqv};
                    default:         next_st.rdata = 32'h0000_0000;
                endcase
            end
        end else begin
            next_st.bus = tpc_pkg::TPC_BUS_IDLE;
        end

        if (wr_ack) begin
            unique case (word_addr)
                `TPC_OFF_CTL_LO: next_st.ctl_lo = merge16(st.ctl_lo, avs_writedata,
                                     avs_byteenable) & `TPC_CTL_LO_MASK;
                `TPC_OFF_CTL_HI: next_st.ctl_hi = merge16(st.ctl_hi, avs_writedata,
                                     avs_byteenable) & `TPC_CTL_HI_MASK;
                `TPC_OFF_CNT_LO: next_st.cnt_lo = merge16(st.cnt_lo, avs_writedata,
                                     avs_byteenable);
                `TPC_OFF_CNT_HI: next_st.cnt_hi = merge16(st.cnt_hi, avs_writedata,
                                     avs_byteenable);
                `TPC_OFF_PER_LO: next_st.per_lo = merge16(st.per_lo, avs_writedata,
                                     avs_byteenable);
                `TPC_OFF_PER_HI: next_st.per_hi = merge16(st.per_hi, avs_writedata,
                                     avs_byteenable);
                `TPC_OFF_IRQ:    irqv = merge16(irqv, avs_writedata, avs_byteenable);
                default: ;
            endcase
        end
        next_st.ip_hi = irqv[14:12];
        next_st.ip_lo = irqv[10:8];
        next_st.ie_hi = irqv[5];
        next_st.ie_lo = irqv[4];
        // a hardware event in the clearing cycle survives the clear
        next_st.flag_hi = irqv[1] || set_hi;
        next_st.flag_lo = irqv[0] || set_lo;
        next_st.irq_lo = next_st.flag_lo && next_st.ie_lo && !cat;
        next_st.irq_hi = next_st.flag_hi && next_st.ie_hi;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st        <= '0;
            st.bus    <= tpc_pkg::TPC_BUS_IDLE;
            st.ctl_lo <= `TPC_CTL_RST;
            st.ctl_hi <= `TPC_CTL_RST;
            st.cnt_lo <= `TPC_CNT_RST;
            st.cnt_hi <= `TPC_CNT_RST;
            st.per_lo <= `TPC_PER_RST;
            st.per_hi <= `TPC_PER_RST;
        end else begin
            st <= next_st;
        end
    end

    // idle code has bit 0 set, so waitrequest is a plain state bit
    assign avs_waitrequest = st.bus[0];
    assign avs_readdata    = st.rdata;
    assign irq_lo          = st.irq_lo;
    assign irq_hi          = st.irq_hi;
    assign irq_priority_lo = st.ip_lo;
    assign irq_priority_hi = st.ip_hi;
    assign adc_trigger     = st.adc;
    assign dma_req_lo      = st.dma_lo;
    assign dma_req_hi      = st.dma_hi;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer late");
    a_ctl_reserved: assert property (((st.ctl_lo & ~`TPC_CTL_LO_MASK) == 16'h0000) &&
        ((st.ctl_hi & ~`TPC_CTL_HI_MASK) == 16'h0000)) else $error("reserved bit set");
    a_stop_holds: assert property (!st.ctl_lo[`TPC_BIT_ON] && !cat && !wr_ack
        |=> $stable(st.cnt_lo)) else $error("stopped timer moved");
    a_idle_halt: assert property (idle_mode && st.ctl_lo[`TPC_BIT_SIDL] && !wr_ack
        |=> $stable(st.cnt_lo) && ($stable(st.cnt_hi) || !$past(cat))) else $error("idle ran");
    a_wrap_flag: assert property (!cat && tick_lo && st.cnt_lo == st.per_lo && !wr_ack
        |=> st.cnt_lo == 16'h0000 && st.flag_lo && dma_req_lo == HAS_DMA)
        else $error("wrap missed");
    a_lo_irq_muted: assert property (cat && !wr_ack |=> $stable(st.flag_lo) && !irq_lo)
        else $error("lower irq used");
    a_carry_up: assert property (cat && tick_lo && st.cnt_lo == 16'hFFFF && cnt32 != per32
        && !wr_ack |=> st.cnt_hi == $past(st.cnt_hi) + 16'h0001 && st.cnt_lo == 16'h0000)
        else $error("carry lost");
    a_adc_chained: assert property (adc_trigger |-> $past(cat) && st.flag_hi)
        else $error("trigger unchained");
    a_dma_allowed: assert property (!HAS_DMA |-> !dma_req_lo && !dma_req_hi)
        else $error("dma from pair");
    a_gate_flag: assert property (gfall_lo && !cat |=> st.flag_lo)
        else $error("gate fall lost");
    // upper clock and gate fall have no say while chained
    a_upper_ignored: assert property (cat |-> !tick_hi && !gfall_hi)
        else $error("upper ran chained");
    a_gate_hold: assert property (!cat && run_lo && !st.ctl_lo[`TPC_BIT_CS] &&
        st.ctl_lo[`TPC_BIT_GATE] && !pin_s[2] && !wr_ack |=> $stable(st.cnt_lo))
        else $error("gate low counted");
    a_hi_wrap: assert property (!cat && tick_hi && st.cnt_hi == st.per_hi && !wr_ack
        |=> st.cnt_hi == 16'h0000 && st.flag_hi && dma_req_hi == HAS_DMA)
        else $error("upper wrap missed");
    a_hi_halts: assert property (!st.ctl_hi[`TPC_BIT_ON] && !cat && !wr_ack
        |=> $stable(st.cnt_hi))
        else $error("stopped upper moved");
    a_read_upper: assert property (!avs_waitrequest |->
        avs_readdata[31:16] == 16'h0000)
        else $error("upper read lanes set");
    a_hi_gate_flag: assert property (gfall_hi |=> st.flag_hi)
        else $error("upper gate fall lost");
    a_adc_only_pair: assert property (!cat |=> !adc_trigger)
        else $error("trigger while single");

    c_wrap32: cover property (adc_trigger);
    c_gate_fall: cover property (gfall_lo);
    c_ext_tick: cover property (tick_lo && st.ctl_lo[`TPC_BIT_CS]);
    c_read_ack: cover property (avs_read && !avs_waitrequest);
    c_idle_halt: cover property (idle_mode && st.ctl_lo[`TPC_BIT_ON] && !run_lo);
endmodule : tpc_top
`default_nettype wire

// ### shared/tpc_defs.svh
// register offsets, control fields and reset values of the timer pair
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

`define TPC_OFF_CTL_LO   5'h00
`define TPC_OFF_CTL_HI   5'h04
`define TPC_OFF_CNT_LO   5'h08
`define TPC_OFF_CNT_HI   5'h0C
`define TPC_OFF_PER_LO   5'h10
`define TPC_OFF_PER_HI   5'h14
`define TPC_OFF_IRQ      5'h18

`define TPC_BIT_ON       15
`define TPC_BIT_SIDL     13
`define TPC_BIT_GATE     6
`define TPC_BIT_PS_HI    5
`define TPC_BIT_PS_LO    4
`define TPC_BIT_CAT      3
`define TPC_BIT_CS       1

`define TPC_CTL_LO_MASK  16'hA07A
`define TPC_CTL_HI_MASK  16'hA072
`define TPC_CTL_RST      16'h0000
`define TPC_CNT_RST      16'h0000
`define TPC_PER_RST      16'hFFFF

`define TPC_PS_LAST_1    8'h00
`define TPC_PS_LAST_8    8'h07
`define TPC_PS_LAST_64   8'h3F
`define TPC_PS_LAST_256  8'hFF

`endif

// ### shared/tpc_pkg.sv
// types shared by the timer pair modules
`default_nettype none
package tpc_pkg;
    typedef enum logic [1:0] {
        TPC_BUS_IDLE = 2'b01,
        TPC_BUS_ACK  = 2'b10
    } tpc_bus_e;

    typedef struct packed {
        tpc_bus_e    bus;
        logic [31:0] rdata;
        logic [15:0] ctl_lo;
        logic [15:0] ctl_hi;
        logic [15:0] cnt_lo;
        logic [15:0] cnt_hi;
        logic [15:0] per_lo;
        logic [15:0] per_hi;
        logic        flag_lo;
        logic        flag_hi;
        logic        ie_lo;
        logic        ie_hi;
        logic [2:0]  ip_lo;
        logic [2:0]  ip_hi;
        logic        ext_d_lo;
        logic        ext_d_hi;
        logic        gate_d_lo;
        logic        gate_d_hi;
        logic        tick_b;
        logic        adc;
        logic        dma_lo;
        logic        dma_hi;
        logic        irq_lo;
        logic        irq_hi;
    } tpc_top_s;
endpackage : tpc_pkg
`default_nettype wire

// ### tb/timer_pair_concatenation_test.sv
// self-checking bench for the timer pair, random periods among corner cases
`timescale 1ns/10ps
`default_nettype none
module timer_pair_concatenation_test;
    logic        clk, rst_b, rd, wr, idle, run_src, gate_cmd, ext, gate, wait_r;
    logic        irq_lo, irq_hi, adc, dma_lo, dma_hi;
    logic [2:0]  pri_lo, pri_hi;
    logic [3:0]  be;
    logic [4:0]  adr;
    logic [7:0]  edges;
    logic [15:0] v, w;
    logic [31:0] wdat, rdat;
    int          err_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          i, p, t0;
    int          nd_dma = 0;
    int          nd_trig = 0;
    logic        nd_lo, nd_hi, nd_adc;

    tpc_top #(.HAS_DMA(1'b1)) dut (
        .clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wait_r), .external_timer_clock_pin_lo(ext),
        .external_timer_clock_pin_hi(ext), .gate_pin_lo(gate), .gate_pin_hi(gate),
        .idle_mode(idle), .irq_lo(irq_lo), .irq_hi(irq_hi), .irq_priority_lo(pri_lo),
        .irq_priority_hi(pri_hi), .adc_trigger(adc), .dma_req_lo(dma_lo),
        .dma_req_hi(dma_hi));

    tpc_pin_src src (.clk(clk), .rst_b(rst_b), .run(run_src), .gate_cmd(gate_cmd),
        .ext_clk(ext), .gate(gate), .edges(edges));

    // second pair built without the memory-transfer path, same stimulus
    tpc_top #(.HAS_DMA(1'b0)) dut_nodma (
        .clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(),
        .avs_waitrequest(), .external_timer_clock_pin_lo(ext),
        .external_timer_clock_pin_hi(ext), .gate_pin_lo(gate), .gate_pin_hi(gate),
        .idle_mode(idle), .irq_lo(), .irq_hi(), .irq_priority_lo(),
        .irq_priority_hi(), .adc_trigger(nd_adc), .dma_req_lo(nd_lo),
        .dma_req_hi(nd_hi));

    function automatic int exp_gap(input logic [1:0] ps, input int per);
        return (per + 1) * (ps == 2'b11 ? 256 : ps == 2'b10 ? 64 : ps == 2'b01 ? 8 : 1);
    endfunction : exp_gap

    // implemented bits only: 15, 13, 6, 5:4, 1, and 3 on the lower timer
    function automatic logic [15:0] exp_ctl(input logic [15:0] d, input bit up);
        return d & (up ? 16'ha072 : 16'ha07a);
    endfunction : exp_ctl

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic chk_n(input string nm, input int e, input int s);
        cmp_count++;
        if (s != e) begin
            err_count++;
            $display("mismatch %s expected %0d seen %0d", nm, e, s);
        end
    endtask : chk_n

    // request held until waitrequest is sampled low; lanes 3:2 are don't-care
    task automatic bus(input logic we, input logic [4:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        @(posedge clk);
        adr  <= a;
        wdat <= {16'h0000, d};
        be   <= {2'($urandom), 2'b11};
        wr   <= we;
        rd   <= !we;
        @(posedge clk);
        while (wait_r !== 1'b0) @(posedge clk);
        q = rdat[15:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic wreg(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg

    task automatic rreg(input logic [4:0] a, output logic [15:0] q);
        bus(1'b0, a, 16'h0000, q);
    endtask : rreg

    // stop, mode, periods, counts, irq, then run last
    task automatic setup(input logic [15:0] cl, ch, pl, ph, c0, c1, iq);
        wreg(5'h00, 16'h0000);
        wreg(5'h04, 16'h0000);
        wreg(5'h00, cl & 16'h7fff);
        wreg(5'h10, pl);
        wreg(5'h14, ph);
        wreg(5'h08, c0);
        wreg(5'h0c, c1);
        wreg(5'h18, iq);
        wreg(5'h04, ch);
        wreg(5'h00, cl);
    endtask : setup

    // cycles between two successive pulses: 0 lower dma, 1 upper dma, 2 adc
    task automatic gap(input int s, input int e);
        int t[2];
        for (int k = 0; k < 2; k++) begin
            t[k] = -1;
            while (t[k] < 0) begin
                @(posedge clk);
                if ((s == 0 ? dma_lo : s == 1 ? dma_hi : adc) === 1'b1) t[k] = cyc;
            end
        end
        chk_n("pulse gap", e, t[1] - t[0]);
    endtask : gap

    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // whole run takes well under 20000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        nd_dma <= nd_dma + int'(nd_lo || nd_hi);
        nd_trig <= nd_trig + int'(nd_adc);
        if (cyc == 40000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        {rst_b, rd, wr, idle, run_src, gate_cmd} = 6'h00;
        adr = 5'h00;
        wdat = 32'h0000_0000;
        be = 4'h3;
        void'($urandom(6));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (i = 0; i < 8; i++) begin
            rreg(5'(i * 4), v);
            chk("reset value", (i == 4 || i == 5) ? 16'hffff : 16'h0000, v);
        end
        for (i = 0; i < 4; i++) begin
            w = (i == 0) ? 16'hffff : 16'($urandom);
            wreg(5'h00, w);
            wreg(5'h04, w);
            wreg(5'h1c, w);
            rreg(5'h00, v);
            chk("lower control", exp_ctl(w, 1'b0), v);
            rreg(5'h04, v);
            chk("upper control", exp_ctl(w, 1'b1), v);
            rreg(5'h1c, v);
            chk("unmapped", 16'h0000, v);
        end
        w = {1'b0, 3'($urandom), 1'b0, 3'($urandom), 8'h00};
        wreg(5'h18, w);
        repeat (2) @(posedge clk);
        chk("priorities", {10'h000, w[14:12], w[10:8]}, {10'h000, pri_hi, pri_lo});
        for (i = 0; i < 4; i++) begin
            p = 1 + $urandom_range(3);
            t0 = 1 + $urandom_range(3);
            w = 16'h8000 | 16'(i << 4);
            setup(w, w, 16'(p), 16'(t0), '0, '0, '0);
            gap(0, exp_gap(2'(i), p));
            gap(1, exp_gap(2'(i), t0));
        end
        // upper run, source and prescale set on purpose; chained they must not matter
        p = 2 + $urandom_range(5);
        setup(16'h8018, 16'h8032, 16'(p), '0, '0, '0, 16'h0030);
        gap(2, exp_gap(2'b01, p));
        gap(1, exp_gap(2'b01, p));
        chk("irq pair", 16'h0002, {14'h0000, irq_hi, irq_lo});
        setup(16'h8008, '0, 16'h0003, 16'h0002, 16'hfff0, '0, '0);
        repeat (60) @(posedge clk);
        wreg(5'h00, 16'h0008);
        rreg(5'h0c, v);
        chk("count high word", 16'h0001, v);
        setup(16'h8008, 16'h2000, 16'hffff, 16'hffff, '0, '0, '0);
        idle <= 1'b1;
        repeat (3) @(posedge clk);
        rreg(5'h08, v);
        repeat (30) @(posedge clk);
        rreg(5'h08, w);
        chk("halted count", v, w);
        wreg(5'h04, 16'h0000);
        rreg(5'h08, v);
        chk("idle running", 16'h0001, {15'h0000, v !== w});
        wreg(5'h00, 16'ha008);
        rreg(5'h08, v);
        rreg(5'h08, w);
        chk("lower halt in idle", v, w);
        idle <= 1'b0;
        setup(16'h8052, 16'h8002, 16'hffff, 16'hffff, '0, '0, '0);
        t0 = int'(edges) + 16;
        run_src <= 1'b1;
        while (int'(edges) < t0) @(posedge clk);
        run_src <= 1'b0;
        repeat (30) @(posedge clk);
        rreg(5'h08, v);
        chk("lower external count", 16'h0002, v);
        rreg(5'h0c, v);
        chk("upper external count", 16'h0010, v);
        setup(16'h8040, 16'h8040, 16'hffff, 16'hffff, '0, '0, 16'h0030);
        repeat (10) @(posedge clk);
        rreg(5'h08, v);
        chk("gate low count", 16'h0000, v);
        gate_cmd <= 1'b1;
        repeat (40) @(posedge clk);
        gate_cmd <= 1'b0;
        chk("irq before fall", 16'h0000, {14'h0000, irq_hi, irq_lo});
        repeat (10) @(posedge clk);
        rreg(5'h08, v);
        chk("gated count", 16'h0001, {15'h0000, v >= 16'h0025 && v <= 16'h002b});
        rreg(5'h0c, w);
        chk("upper gated count", 16'h0001, {15'h0000, w >= 16'h0025 && w <= 16'h002b});
        chk("irq after fall", 16'h0003, {14'h0000, irq_hi, irq_lo});
        chk_n("dma from second pair", 0, nd_dma);
        chk_n("second pair triggered", 1, int'(nd_trig > 0));
        end_sim();
    end
endmodule : timer_pair_concatenation_test
`default_nettype wire

// ### tb/tpc_pin_src.sv
// pin source model: external timer clock and gate level at the timer pins
`timescale 1ns/10ps
`default_nettype none
module tpc_pin_src (
    input  wire logic       clk,      // device clock
    input  wire logic       rst_b,    // async reset, active low
    input  wire logic       run,      // emit clock edges while high
    input  wire logic       gate_cmd, // wanted gate level
    output logic            ext_clk,  // external timer clock
    output logic            gate,     // gate level at the pin
    output logic      [7:0] edges     // rising edges sent so far
);
    logic [1:0] ph;

    // eight clk per period so the pin filter sees every level;
    // a started period is finished, so the line idles low between bursts
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph      <= 2'h0;
            ext_clk <= 1'b0;
            edges   <= 8'h00;
            gate    <= 1'b0;
        end else begin
            gate <= gate_cmd;
            if (run || ext_clk) begin
                ph <= ph + 2'h1;
                if (ph == 2'h3) begin
                    ext_clk <= !ext_clk;
                    edges   <= edges + {7'h00, !ext_clk};
                end
            end
        end
    end
endmodule : tpc_pin_src
`default_nettype wire
